//--- esb_pkg.sv
// Functional notes
// - Sample read data 45 ns after address
// - Sample read data 22 ns after gate low
// - Address stable 35 ns before write end
// - Address may change at write end
// - Address may arrive at write start
// - Write data 25 ns before write end
// - Write data may drop at write end
// - Wait 45 ns after retention before access
// - Deselect may coincide with retention entry
// - Write spans overlap of strobe and selects
package esb_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_ACC_NS = 45;
  localparam int T_OE_NS = 22;
  localparam int T_ERR_NS = 45;
  localparam int T_AW_NS = 35;
  localparam int T_SD_NS = 25;
  localparam int T_CYC_NS = 45;
  localparam int T_REC_NS = 45;
  localparam int T_HZ_NS = 18;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OE_CYC = (T_OE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERR_CYC = (T_ERR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AW_CYC = (T_AW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SD_CYC = (T_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_CYC = (T_CYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = (T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HZ_CYC = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC = (ACC_CYC > ERR_CYC) ? ACC_CYC : ERR_CYC;
  localparam int WR_CYC = (AW_CYC > SD_CYC) ? AW_CYC : SD_CYC;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } esb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              err;
  } esb_rsp_t;

  typedef struct packed {
    logic              select_active_low_n;
    logic              select_active_high;
    logic              write_n;
    logic              gate_n;
    logic [ADDR_W-1:0] word_address_lines;
  } esb_pins_t;
endpackage

//--- esb_timer.sv
`timescale 1ns/1ns
module esb_timer
(
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst,
  input  wire logic                     i_load,
  input  wire logic [esb_pkg::CNT_W-1:0] i_value,
  output logic                          o_done
);
  logic [esb_pkg::CNT_W-1:0] cnt_reg;
  logic [esb_pkg::CNT_W-1:0] cnt_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (i_load)
    begin
      cnt_next = i_value;
    end
    else if (cnt_reg != esb_pkg::CNT_ZERO)
    begin
      cnt_next = cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      cnt_reg <= esb_pkg::CNT_ZERO;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  // Done depends on the count only; the load request is built from done
  assign o_done = (cnt_reg == esb_pkg::CNT_ZERO);
endmodule

//--- esb_host.sv
`timescale 1ns/1ns
module esb_host
(
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst,
  input  wire logic                      i_req_valid,
  input  wire esb_pkg::esb_req_t         i_req,
  output logic                           o_req_ready,
  output logic                           o_rsp_valid,
  output esb_pkg::esb_rsp_t              o_rsp,
  input  wire logic                      i_retention,
  output esb_pkg::esb_pins_t             o_pins,
  input  wire logic [esb_pkg::DATA_W-1:0] i_data_lines,
  output logic [esb_pkg::DATA_W-1:0]     o_data_lines,
  output logic                           o_data_lines_oe,
  input  wire logic                      i_err
);
  typedef enum logic [2:0] {
    ESB_IDLE,
    ESB_READ,
    ESB_WRITE,
    ESB_GAP,
    ESB_RETAIN,
    ESB_RECOVER
  } esb_state_t;

  esb_state_t                  state_reg;
  esb_state_t                  state_next;
  esb_pkg::esb_pins_t          pins_reg;
  esb_pkg::esb_pins_t          pins_next;
  logic [esb_pkg::DATA_W-1:0]  wdata_reg;
  logic [esb_pkg::DATA_W-1:0]  wdata_next;
  logic                        oe_reg;
  logic                        oe_next;
  esb_pkg::esb_rsp_t           rsp_reg;
  esb_pkg::esb_rsp_t           rsp_next;
  logic                        rsp_valid_reg;
  logic                        rsp_valid_next;
  logic                        load;
  logic [esb_pkg::CNT_W-1:0]   load_value;
  logic                        done;

  esb_timer esb_timer_inst
  (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_load  (load),
    .i_value (load_value),
    .o_done  (done)
  );

  // Access sequencing: pins, write data and bus direction
  always_comb
  begin
    state_next = state_reg;
    pins_next  = pins_reg;
    wdata_next = wdata_reg;
    oe_next    = oe_reg;
    load       = 1'h0;
    load_value = esb_pkg::CNT_ZERO;
    unique case (state_reg)
      ESB_IDLE:
      begin
        if (i_retention)
        begin
          // Deselect in the same cycle retention begins
          pins_next.select_active_low_n = 1'h1;
          pins_next.select_active_high  = 1'h0;
          state_next                    = ESB_RETAIN;
        end
        else if (i_req_valid)
        begin
          // Address, selects and strobe all change together
          pins_next.word_address_lines  = i_req.addr;
          pins_next.select_active_low_n = 1'h0;
          pins_next.select_active_high  = 1'h1;
          pins_next.write_n             = !i_req.write;
          pins_next.gate_n              = i_req.write;
          wdata_next                    = i_req.wdata;
          // Lines driven only while the device is in write mode
          oe_next                       = i_req.write;
          load                          = 1'h1;
          if (i_req.write)
          begin
            load_value = 3'(esb_pkg::WR_CYC - 1);
            state_next = ESB_WRITE;
          end
          else
          begin
            load_value = 3'(esb_pkg::RD_CYC - 1);
            state_next = ESB_READ;
          end
        end
      end
      ESB_READ:
      begin
        // Wait covers address, gate and error flag access together
        if (done)
        begin
          pins_next.gate_n              = 1'h1;
          pins_next.select_active_low_n = 1'h1;
          pins_next.select_active_high  = 1'h0;
          // Gap lets the device float the lines before the next drive
          load       = 1'h1;
          load_value = 3'(esb_pkg::HZ_CYC - 1);
          state_next = ESB_GAP;
        end
      end
      ESB_WRITE:
      begin
        if (done)
        begin
          // Strobe and selects drop together to end the write
          pins_next.write_n             = 1'h1;
          pins_next.select_active_low_n = 1'h1;
          pins_next.select_active_high  = 1'h0;
          // Data released at the ending edge, no hold needed
          oe_next    = 1'h0;
          load       = 1'h1;
          load_value = 3'(esb_pkg::CYC_CYC - esb_pkg::WR_CYC);
          state_next = ESB_GAP;
        end
      end
      ESB_GAP:
      begin
        // Bus turnaround and cycle time before the next access
        if (done)
        begin
          state_next = ESB_IDLE;
        end
      end
      ESB_RETAIN:
      begin
        // Recovery count starts only once the supply is back
        if (!i_retention)
        begin
          load       = 1'h1;
          load_value = 3'(esb_pkg::REC_CYC);
          state_next = ESB_RECOVER;
        end
      end
      ESB_RECOVER:
      begin
        // A new dip restarts the whole recovery wait
        if (i_retention)
        begin
          state_next = ESB_RETAIN;
        end
        else if (done)
        begin
          state_next = ESB_IDLE;
        end
      end
      default:
      begin
        state_next = ESB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      state_reg <= ESB_IDLE;
      pins_reg  <= '{select_active_low_n: 1'h1, select_active_high: 1'h0,
                     write_n: 1'h1, gate_n: 1'h1, word_address_lines: '0};
      wdata_reg <= '0;
      oe_reg    <= 1'h0;
    end
    else
    begin
      state_reg <= state_next;
      pins_reg  <= pins_next;
      wdata_reg <= wdata_next;
      oe_reg    <= oe_next;
    end
  end

  // Response capture at the last cycle of each access
  always_comb
  begin
    rsp_next       = rsp_reg;
    rsp_valid_next = 1'h0;
    if ((state_reg == ESB_READ) && done)
    begin
      // Error flag taken with the data, so both belong to one word
      rsp_next.rdata = i_data_lines;
      rsp_next.err   = i_err;
      rsp_valid_next = 1'h1;
    end
    else if ((state_reg == ESB_WRITE) && done)
    begin
      rsp_next.err   = 1'h0;
      rsp_valid_next = 1'h1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      rsp_reg       <= '0;
      rsp_valid_reg <= 1'h0;
    end
    else
    begin
      rsp_reg       <= rsp_next;
      rsp_valid_reg <= rsp_valid_next;
    end
  end

  // Ready only when the state machine can take a request now
  assign o_req_ready     = (state_reg == ESB_IDLE) && !i_retention;
  assign o_rsp_valid     = rsp_valid_reg;
  assign o_rsp           = rsp_reg;
  assign o_pins          = pins_reg;
  assign o_data_lines    = wdata_reg;
  assign o_data_lines_oe = oe_reg;
endmodule

//--- esb_host_asserts.sv
`timescale 1ns/1ns
module esb_host_asserts
(
  input wire logic               i_mclk,
  input wire logic               i_rst,
  input wire logic               i_req_valid,
  input wire esb_pkg::esb_req_t  i_req,
  input wire logic               o_req_ready,
  input wire logic               o_rsp_valid,
  input wire esb_pkg::esb_rsp_t  o_rsp,
  input wire logic               i_retention,
  input wire esb_pkg::esb_pins_t o_pins,
  input wire logic [7:0]         i_data_lines,
  input wire logic [7:0]         o_data_lines,
  input wire logic               o_data_lines_oe,
  input wire logic               i_err
);
  wire sel = !o_pins.select_active_low_n && o_pins.select_active_high;
  wire wn = o_pins.write_n;
  wire gn = o_pins.gate_n;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_reset_idle: assert property ($fell(i_rst) |-> !sel && wn && gn && !o_data_lines_oe)
    else $error("pins active after reset");
  a_write_len: assert property ($fell(wn) |-> (sel && o_data_lines_oe && !wn)[*2] ##1 wn)
    else $error("write strobe too short");
  a_write_hold: assert property ($fell(wn) |=> $stable(o_pins.word_address_lines) && $stable(o_data_lines))
    else $error("address or data moved in write");
  a_write_sel: assert property (!wn |-> sel)
    else $error("write strobe without select");
  a_read_len: assert property ($fell(gn) |-> (!gn && sel && !o_data_lines_oe)[*3] ##1 gn)
    else $error("read window wrong");
  a_read_rsp: assert property ($fell(gn) |-> ##3 o_rsp_valid)
    else $error("read answer late");
  a_write_rsp: assert property ($fell(wn) |-> ##2 o_rsp_valid)
    else $error("write answer late");
  a_rsp_pulse: assert property (o_rsp_valid |=> !o_rsp_valid)
    else $error("answer longer than a cycle");
  a_ret_stall: assert property (i_retention |-> !o_req_ready)
    else $error("ready during retention");
  a_ret_recover: assert property ($fell(i_retention) |-> !o_req_ready[*2])
    else $error("recovery too short");
  a_ret_deselect: assert property (i_retention[*5] |-> !sel)
    else $error("selected in retention");
  a_ret_no_access: assert property ((i_retention && !sel) |=> !sel)
    else $error("access started in retention");
  c_write: cover property ($fell(wn));
  c_err_read: cover property ($fell(gn) ##3 o_rsp.err);
  c_recover: cover property ($fell(i_retention));
endmodule
bind esb_host esb_host_asserts esb_host_asserts_inst (.i_mclk, .i_rst, .i_req_valid, .i_req,
  .o_req_ready, .o_rsp_valid, .o_rsp, .i_retention, .o_pins, .i_data_lines, .o_data_lines,
  .o_data_lines_oe, .i_err);

//--- esb_dev.sv
`timescale 1ns/1ns
module esb_dev
(
  input  wire esb_pkg::esb_pins_t i_pins,
  input  wire logic [7:0]         i_data_lines,
  output logic [7:0]              o_data,
  output logic                    o_drive,
  output logic                    o_err
);
  logic [7:0]  mem [int];
  bit          bad [int];
  int          n_wr = 0;
  logic        tog = 1'b0;
  logic        sel;
  logic        wr_on;
  logic [7:0]  d_dly;
  logic [19:0] a_dly;
  wire [19:0]  a = i_pins.word_address_lines;
  // Floating lines toggle so a stale value never passes
  always #7 tog = ~tog;
  assign sel = !i_pins.select_active_low_n && i_pins.select_active_high;
  assign wr_on = sel && !i_pins.write_n;
  assign #1 d_dly = i_data_lines;
  assign #1 a_dly = a;
  always @(negedge wr_on)
  begin
    // Power-up edge from unknown carries no address
    if (!$isunknown(a_dly))
    begin
      mem[a_dly] = d_dly;
      bad[a_dly] = 1'b0;
      n_wr++;
    end
  end
  assign o_drive = sel && !i_pins.gate_n && i_pins.write_n;
  // Read never touches bad, so no write-back
  always @(o_drive or a or tog or n_wr or sel)
  begin
    // Old word stays on the lines for a while after the address moves
    o_data <= #10 ((o_drive === 1'b1) && mem.exists(a)) ? mem[a] : {8{tog}};
    o_err = (sel === 1'b1) ? (bad.exists(a) && bad[a]) : tog;
  end
endmodule

//--- esb_host_test.sv
`timescale 1ns/1ns
module esb_host_test;
  logic               i_mclk = 1'h0;
  logic               i_rst = 1'h1;
  logic               i_req_valid = 1'h0;
  logic               i_retention = 1'h0;
  logic               drv;
  esb_pkg::esb_req_t  i_req = '0;
  esb_pkg::esb_rsp_t  o_rsp;
  esb_pkg::esb_pins_t o_pins;
  logic               o_req_ready;
  logic               o_rsp_valid;
  logic               oe;
  logic               err;
  logic [7:0]         hd;
  logic [7:0]         dd;
  logic [7:0]         bus;
  int                 n_errors = 0;
  int                 checks_done = 0;
  int                 k;
  always #10 i_mclk = ~i_mclk;
  assign bus = oe ? hd : dd;
  esb_host esb_host_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp),
    .i_retention(i_retention), .o_pins(o_pins), .i_data_lines(bus), .o_data_lines(hd),
    .o_data_lines_oe(oe), .i_err(err));
  esb_dev esb_dev_inst (.i_pins(o_pins), .i_data_lines(bus), .o_data(dd), .o_drive(drv),
    .o_err(err));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("BAD %s exp %h got %h", what, exp, got);
      n_errors++;
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Host and device must never drive the lines together
  always @(negedge i_mclk)
  begin
    if (oe === 1'h1)
      chk("drive", 32'h0, drv);
  end
  task wait_rsp;
    @(negedge i_mclk);
    for (k = 0; k < 20 && o_rsp_valid !== 1'h1; k++) @(negedge i_mclk);
    chk("rsp_valid", 32'h1, o_rsp_valid);
  endtask
  task xfer(input logic w, input logic [19:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_req_valid <= 1'h1;
    i_req <= '{w, a, d};
    @(negedge i_mclk);
    for (k = 0; k < 20 && o_req_ready !== 1'h1; k++) @(negedge i_mclk);
    chk("ready", 32'h1, o_req_ready);
    @(posedge i_mclk);
    i_req_valid <= 1'h0;
    wait_rsp;
  endtask
  task t_rw;
    xfer(1'h1, 20'hFFFFF, 8'hA5);
    xfer(1'h1, 20'h00000, 8'h5A);
    xfer(1'h0, 20'hFFFFF, 8'h00);
    chk("rdata", 8'hA5, o_rsp.rdata);
    chk("err", 32'h0, o_rsp.err);
    xfer(1'h0, 20'h00000, 8'h00);
    chk("rdata", 8'h5A, o_rsp.rdata);
    $display("t_rw done");
  endtask
  task t_ecc;
    int nw;
    xfer(1'h1, 20'h12345, 8'h3C);
    esb_dev_inst.bad[20'h12345] = 1'b1;
    nw = esb_dev_inst.n_wr;
    xfer(1'h0, 20'h12345, 8'h00);
    chk("rdata", 8'h3C, o_rsp.rdata);
    chk("err", 32'h1, o_rsp.err);
    chk("writes", nw, esb_dev_inst.n_wr);
    chk("bad", 32'h1, esb_dev_inst.bad[20'h12345]);
    $display("t_ecc done");
  endtask
  task t_ret;
    @(posedge i_mclk);
    i_retention <= 1'h1;
    i_req_valid <= 1'h1;
    i_req <= '{1'h0, 20'hFFFFF, 8'h00};
    repeat (6) @(negedge i_mclk);
    chk("ready", 32'h0, o_req_ready);
    chk("select_active_high", 32'h0, o_pins.select_active_high);
    @(posedge i_mclk);
    i_retention <= 1'h0;
    @(negedge i_mclk);
    for (k = 0; k < 20 && o_req_ready !== 1'h1; k++) @(negedge i_mclk);
    chk("recovery", 32'h1, k >= esb_pkg::REC_CYC - 1);
    @(posedge i_mclk);
    i_req_valid <= 1'h0;
    wait_rsp;
    chk("rdata", 8'hA5, o_rsp.rdata);
    $display("t_ret done");
  endtask
  initial
  begin
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'h0;
    @(negedge i_mclk);
    chk("oe", 32'h0, oe);
    chk("select_active_low_n", 32'h1, o_pins.select_active_low_n);
    t_rw;
    t_ecc;
    t_ret;
    test_done;
  end
  initial
  begin
    #100000;
    n_errors++;
    test_done;
  end
endmodule
